// [rtl/spl_consts.vh]
// Contract
// (RL1) Stack pointer holds next free word; stack grows toward higher addresses.
// (RL2) Push writes at pointer then increments; pop decrements then reads.
// (RL3) Call push zero-extends the counter so the top pushed bit is clear.
// (RL4) Exception push places status low byte above the counter value.
// (RL5) Stack limit register has no defined reset value until written.
// (RL6) Limit register bit zero always reads and acts as zero.
// (RL7) Every stack-pointer-based effective address is compared with the limit; pop addresses are not compared.
// (RL8) Push at pointer equal to limit passes; the next push traps.
// (RL9) Stack address below the fixed lower bound raises an underflow trap.
// (RL10) Software avoids stack-pointer indirect read right after a limit write.
// (RL11) Stack error trap request is raised in the same cycle as the address.
// (RL12) Each push or pop moves the pointer by two byte addresses.
`ifndef SPL_CONSTS_VH
`define SPL_CONSTS_VH
`define SPL_WORD_W 16
`define SPL_LOWER_BOUND 16'h0800
`define SPL_STEP 16'h0002
`define SPL_SP_RESET 16'h0800
`define SPL_PC_W 23
`define SPL_SRL_W 8
`define SPL_PUSH_W 32
`define SPL_OP_NONE 2'h0
`define SPL_OP_PUSH 2'h1
`define SPL_OP_POP 2'h2
`define SPL_OP_EA 2'h3
`endif

// [rtl/spl_addr_cmp.v]
`timescale 1ns/1ps
`include "spl_consts.vh"
module spl_addr_cmp #(
    parameter W = 16
) (
    input wire [W-1:0] ea_i,
    input wire [W-1:0] limit_i,
    input wire [W-1:0] lower_i,
    output wire over_o,
    output wire under_o
);
    // **************
    // Bound compare
    // **************
    assign over_o = (ea_i > limit_i); // [RL7] [RL8]
    assign under_o = (ea_i < lower_i); // [RL9]
endmodule // spl_addr_cmp

// [rtl/spl_stack_unit.v]
`timescale 1ns/1ps
`include "spl_consts.vh"
module spl_stack_unit #(
    parameter W = 16,
    parameter PC_W = 23
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [1:0] op_i,
    input wire [W-1:0] ea_i,
    input wire exc_i,
    input wire [PC_W-1:0] pc_i,
    input wire [7:0] status_low_byte_i,
    input wire sp_wr_i,
    input wire [W-1:0] sp_wdata_i,
    input wire lim_wr_i,
    input wire [W-1:0] lim_wdata_i,
    output wire [W-1:0] stack_addr_o,
    output wire [W-1:0] push_lo_o,
    output wire [W-1:0] push_hi_o,
    output wire trap_o,
    output wire overflow_o,
    output wire underflow_o,
    output reg [W-1:0] stack_pointer_o,
    output wire [W-1:0] stack_limit_o
);
    // **************
    // Constants
    // **************
    // Floor sits just above the special register region
    localparam [W-1:0] LOWER_BOUND = `SPL_LOWER_BOUND;
    localparam [W-1:0] STEP = `SPL_STEP;
    localparam [W-1:0] SP_RESET = `SPL_SP_RESET;
    localparam HI_W = `SPL_PUSH_W - W;
    localparam PC_HI_W = PC_W - W;
    localparam PAD_W = HI_W - PC_HI_W;

    // **************
    // State
    // **************
    reg [W-1:0] stack_pointer_reg;
    reg [W-1:0] stack_pointer_next;
    reg [W-1:0] stack_limit_reg;
    reg [W-1:0] addr;
    reg is_push;
    reg is_pop;
    reg is_ea;
    reg limit_en;
    reg floor_en;
    reg over_hit;
    reg under_hit;
    reg [HI_W-1:0] hi_word;
    wire over;
    wire under;
    wire [W-1:0] sp_wr_word;
    wire [W-1:0] lim_wr_word;
    wire [PC_HI_W-1:0] pc_hi;

    // **************
    // Op decode
    // **************
    // Pop is only held to the floor; the limit guards pushes and EA accesses
    always @*
    begin
        is_push = 1'b0;
        is_pop = 1'b0;
        is_ea = 1'b0;
        limit_en = 1'b0;
        floor_en = 1'b0;
        case (op_i)
            `SPL_OP_PUSH:
            begin
                is_push = 1'b1;
                limit_en = 1'b1;
                floor_en = 1'b1;
            end
            `SPL_OP_POP:
            begin
                is_pop = 1'b1;
                floor_en = 1'b1;
            end
            `SPL_OP_EA:
            begin
                is_ea = 1'b1;
                limit_en = 1'b1; // [RL7]
                floor_en = 1'b1;
            end
            default:
            begin
                is_push = 1'b0;
                is_pop = 1'b0;
            end
        endcase
    end

    // **************
    // Address generation
    // **************
    // Idle cycles show the pointer, so the address bus does not toggle needlessly
    always @*
    begin
        if (is_push)
            addr = stack_pointer_reg; // [RL2]
        else if (is_pop)
            addr = stack_pointer_reg - STEP; // [RL2] [RL12]
        else if (is_ea)
            addr = ea_i; // [RL7]
        else
            addr = stack_pointer_reg;
    end

    // **************
    // Address output
    // **************
    assign stack_addr_o = addr;

    // **************
    // Pointer update
    // **************
    assign sp_wr_word = {sp_wdata_i[W-1:1], 1'b0};

    // A direct write wins over the op, so software can reseat the stack at once
    always @*
    begin
        if (sp_wr_i)
            stack_pointer_next = sp_wr_word;
        else if (is_push)
            stack_pointer_next = stack_pointer_reg + STEP; // [RL1] [RL2] [RL12]
        else if (is_pop)
            stack_pointer_next = stack_pointer_reg - STEP; // [RL1] [RL2] [RL12]
        else
            stack_pointer_next = stack_pointer_reg;
    end

    // **************
    // Pointer register
    // **************
    // Reset seats the pointer at the floor, the first legal stack word
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
            stack_pointer_reg <= SP_RESET;
        else
            stack_pointer_reg <= stack_pointer_next;
    end

    // Output copy keeps the port a flop of its own, apart from internal fanout
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
            stack_pointer_o <= SP_RESET;
        else
            stack_pointer_o <= stack_pointer_next;
    end

    // **************
    // Limit register
    // **************
    assign lim_wr_word = {lim_wdata_i[W-1:1], 1'b0}; // [RL6]

    // No reset branch on purpose: undefined until software writes it
    always @(posedge sys_clk_i)
    begin
        if (lim_wr_i)
            stack_limit_reg <= lim_wr_word; // [RL5] [RL6]
    end

    assign stack_limit_o = {stack_limit_reg[W-1:1], 1'b0}; // [RL6]

    // **************
    // Bound compare
    // **************
    spl_addr_cmp #(
        .W(W)
    ) u_cmp (
        .ea_i(addr),
        .limit_i(stack_limit_reg),
        .lower_i(LOWER_BOUND),
        .over_o(over),
        .under_o(under)
    );

    // **************
    // Trap qualify
    // **************
    // Reset masks the trap, so a pointer being reseated cannot fire it
    always @*
    begin
        over_hit = 1'b0;
        under_hit = 1'b0;
        if (!rst_i)
        begin
            over_hit = over && limit_en; // [RL7] [RL8]
            under_hit = under && floor_en; // [RL9]
        end
    end

    // **************
    // Trap outputs
    // **************
    // Combinational so the trap lands in the cycle the address is formed
    assign overflow_o = over_hit; // [RL11]
    assign underflow_o = under_hit; // [RL11]
    assign trap_o = over_hit || under_hit; // [RL11]

    // **************
    // Pushed high word
    // **************
    // An exception push keeps every counter bit; a clear bit and the status byte fill the pad
    assign pc_hi = pc_i[PC_W-1:W];

    always @*
    begin
        case (exc_i)
            1'b1:
                hi_word = {status_low_byte_i, 1'b0, pc_hi}; // [RL4]
            default:
                hi_word = {{PAD_W{1'b0}}, pc_hi}; // [RL3]
        endcase
    end

    assign push_hi_o = hi_word;

    // **************
    // Pushed low word
    // **************
    assign push_lo_o = pc_i[W-1:0];
endmodule // spl_stack_unit

// [sim/spl_stack_properties.sv]
`timescale 1ns/1ps
module spl_stack_props (
    input wire sys_clk_i,
    input wire rst_i,
    input wire exc_i,
    input wire sp_wr_i,
    input wire lim_wr_i,
    input wire overflow_o,
    input wire underflow_o,
    input wire trap_o,
    input wire [1:0] op_i,
    input wire [7:0] status_low_byte_i,
    input wire [22:0] pc_i,
    input wire [15:0] ea_i,
    input wire [15:0] lim_wdata_i,
    input wire [15:0] stack_addr_o,
    input wire [15:0] push_hi_o,
    input wire [15:0] stack_pointer_o,
    input wire [15:0] stack_limit_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire psh = op_i == 2'h1;
    chk_trap_or: assert property (trap_o==(overflow_o|underflow_o)) else $error("trap");
    chk_push_addr: assert property (psh |-> stack_addr_o==stack_pointer_o)
        else $error("push address");
    chk_ea_addr: assert property (op_i==2'h3 |-> stack_addr_o==ea_i) else $error("ea");
    chk_push_step: assert property (psh && !sp_wr_i |=>
        stack_pointer_o==$past(stack_pointer_o)+16'h0002) else $error("push step");
    chk_lim_align: assert property (lim_wr_i |=>
        stack_limit_o==($past(lim_wdata_i)&16'hFFFE)) else $error("limit");
    chk_over_cmp: assert property (psh |-> overflow_o==(stack_pointer_o>stack_limit_o))
        else $error("overflow");
    chk_under_cmp: assert property (op_i!=2'h0 |-> underflow_o==(stack_addr_o<16'h0800))
        else $error("underflow");
    chk_hi_word: assert property (push_hi_o==(exc_i ? {status_low_byte_i,1'b0,pc_i[22:16]}
        : {9'h0,pc_i[22:16]})) else $error("high word");
endmodule // spl_stack_props

// [sim/spl_core_model.sv]
`timescale 1ns/1ps
module spl_core_model (
    input wire clk_i,
    input wire lw_i,
    input wire [1:0] rq_i,
    output wire [1:0] op_o
);
    reg lw_reg;
    always @(posedge clk_i)
        lw_reg <= lw_i;
    // Limit compare is not yet valid one cycle after a write
    assign op_o = (lw_reg && rq_i == 2'h3) ? 2'h0 : rq_i;
endmodule // spl_core_model

// [sim/spl_stack_unit_tb.sv]
`timescale 1ns/1ps
module spl_stack_unit_tb;
    reg sys_clk_i = 0, rst_i = 1, exc_i = 0, sp_wr_i = 0, lim_wr_i = 0;
    reg [1:0] rq = 0;
    reg [15:0] ea_i = 0, sp_wdata_i = 0, lim_wdata_i = 0, sp = 16'h0800, lm;
    reg [22:0] pc_i = 0;
    reg [7:0] status_low_byte_i = 0;
    reg [31:0] r = 32'hBDBB27A6;
    wire [1:0] op_i;
    wire [15:0] stack_addr_o, push_lo_o, push_hi_o, stack_pointer_o, stack_limit_o;
    wire trap_o, overflow_o, underflow_o;
    integer n_fail = 0, n_tests = 0, i;
    spl_stack_unit DUT (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .op_i(op_i),
        .ea_i(ea_i),
        .exc_i(exc_i),
        .pc_i(pc_i),
        .status_low_byte_i(status_low_byte_i),
        .sp_wr_i(sp_wr_i),
        .sp_wdata_i(sp_wdata_i),
        .lim_wr_i(lim_wr_i),
        .lim_wdata_i(lim_wdata_i),
        .stack_addr_o(stack_addr_o),
        .push_lo_o(push_lo_o),
        .push_hi_o(push_hi_o),
        .trap_o(trap_o),
        .overflow_o(overflow_o),
        .underflow_o(underflow_o),
        .stack_pointer_o(stack_pointer_o),
        .stack_limit_o(stack_limit_o)
    );
    spl_core_model cm (.clk_i(sys_clk_i), .lw_i(lim_wr_i), .rq_i(rq), .op_o(op_i));
    function [15:0] ad(input [1:0] o);
        ad = o == 2'h3 ? ea_i : o == 2'h2 ? sp - 16'h0002 : sp;
    endfunction
    function [15:0] tp(input [1:0] o);
        reg ov, un;
        begin
            ov = !rst_i && o[0] && ad(o) > lm;
            un = !rst_i && o != 2'h0 && ad(o) < 16'h0800;
            tp = {13'h0, ov || un, ov, un};
        end
    endfunction
    function [15:0] ph(input [22:0] p);
        ph = exc_i ? {status_low_byte_i, 1'b0, p[22:16]} : {9'h0, p[22:16]};
    endfunction
    function [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task cmp(input [23:0] n, input [15:0] e, g);
        begin
            n_tests = n_tests + 1;
            n_fail = n_fail + (e !== g);
            if (e !== g)
                $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task cyc;
        begin
            #5 cmp("ad", ad(op_i), stack_addr_o);
            cmp("trp", tp(op_i), {13'h0, trap_o, overflow_o, underflow_o});
            cmp("phi", ph(pc_i), push_hi_o);
            cmp("plo", pc_i[15:0], push_lo_o);
            sp = rst_i ? 16'h0800 : sp_wr_i ? sp_wdata_i & 16'hFFFE
                : op_i == 2'h1 ? sp + 16'h0002 : op_i == 2'h2 ? sp - 16'h0002 : sp;
            if (lim_wr_i)
                lm = lim_wdata_i & 16'hFFFE;
            @(posedge sys_clk_i);
            #2 cmp("sp", sp, stack_pointer_o);
            cmp("lim", lm, stack_limit_o);
        end
    endtask
    task give_verdict;
        begin
            $display("tests %0d fails %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial
        forever #10 sys_clk_i = ~sys_clk_i;
    initial
    begin
        #20000 n_fail = n_fail + 1;
        give_verdict;
    end
    initial
    begin
        repeat (5) @(posedge sys_clk_i);
        #2 rst_i = 0;
        {lim_wr_i, lim_wdata_i} = {1'b1, 16'h0803};
        cyc;
        {lim_wr_i, rq} = {1'b0, 2'h1};
        repeat (3) cyc;
        {rst_i, rq} = {1'b1, 2'h1};
        repeat (2) cyc;
        rst_i = 0;
        repeat (2) cyc;
        $display("reset done");
        {sp_wr_i, sp_wdata_i, rq} = {1'b1, 16'h0800, 2'h2};
        repeat (2) cyc;
        $display("walk done");
        for (i = 0; i < 400; i = i + 1)
        begin
            r = nx(r);
            {pc_i, status_low_byte_i} = r[30:0];
            {exc_i, sp_wr_i, lim_wr_i, rq} = {r[0], r[4:1] == 4'h0, r[8:5] == 4'h0, r[10:9]};
            {ea_i, sp_wdata_i, lim_wdata_i} = {4'h0, r[27:16], 7'h04, r[24:16], 7'h04, r[31:23]};
            cyc;
        end
        $display("random done");
        give_verdict;
    end
endmodule // spl_stack_unit_tb
bind spl_stack_unit spl_stack_props u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .exc_i(exc_i),
    .sp_wr_i(sp_wr_i),
    .lim_wr_i(lim_wr_i),
    .overflow_o(overflow_o),
    .underflow_o(underflow_o),
    .trap_o(trap_o),
    .op_i(op_i),
    .status_low_byte_i(status_low_byte_i),
    .pc_i(pc_i),
    .ea_i(ea_i),
    .lim_wdata_i(lim_wdata_i),
    .stack_addr_o(stack_addr_o),
    .push_hi_o(push_hi_o),
    .stack_pointer_o(stack_pointer_o),
    .stack_limit_o(stack_limit_o)
);
